// >>> src/atcw_cpu.sv
// Processor end: flushes, waits for room, writes one cell per request
module atcw_cpu
  import atcw_pkg::*;
(
  input wire logic MCLK_I, // 40 MHz clock
  input wire logic RESET_I, // Sync reset, active high
  atcw_if.cpu BUS, // Processor bus and transmit path
  input wire logic SEND_I, // Pulse: write next cell
  input wire logic [7:0] FILL_I, // Seed byte for cell content
  input wire logic TX_READY_I, // Transmit path accepts words
  output logic BUSY_O, // Cell write under way
  output logic DONE_O // Pulse: cell written
);
  import atcw_pkg::*;

  atcw_op_t st_reg;
  logic [3:0] word_reg;
  logic [2:0] step_reg;
  logic [7:0] seed_reg;
  logic flushed_reg, busy_reg, done_reg, rd_pend_reg;
  logic [15:0] addr_reg;
  logic [7:0] wdata_reg;
  logic wr_reg, rd_reg;

  function automatic logic [7:0] cell_byte(input logic [7:0] s, input logic [3:0] w,
    input logic [1:0] b);
    return s + {2'b00, w, 2'b00} + {6'h00, b};
  endfunction

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      st_reg <= ATCW_IDLE;
      word_reg <= '0;
      step_reg <= '0;
      seed_reg <= '0;
      flushed_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= '0;
      wdata_reg <= '0;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
    end else begin
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      done_reg <= 1'b0;
      rd_pend_reg <= rd_reg;
      case (st_reg)
        ATCW_IDLE: begin
          if (!flushed_reg) begin
            step_reg <= step_reg + 3'h1;
            case (step_reg)
              3'h0: begin
                wr_reg <= 1'b1;
                addr_reg <= ADDR_BUF_CTRL;
                wdata_reg <= 8'h10;
              end
              3'h1: begin
                wr_reg <= 1'b1;
                addr_reg <= ADDR_BUF_CTRL;
                wdata_reg <= RST_CTRL_KEEP;
              end
              3'h2: begin
                wr_reg <= 1'b1;
                addr_reg <= ADDR_IRQ_MASK;
                wdata_reg <= 8'h10;
              end
              default: begin
                // one data register read, extraction side
                addr_reg <= ADDR_BYTE3;
                rd_reg <= 1'b1;
                flushed_reg <= 1'b1;
              end
            endcase
          end else if (SEND_I) begin
            seed_reg <= FILL_I;
            busy_reg <= 1'b1;
            st_reg <= ATCW_WAIT;
          end else if (!BUS.irq_n && !rd_reg && !rd_pend_reg) begin
            addr_reg <= ADDR_IRQ_FLAGS;
            rd_reg <= 1'b1;
          end
        end
        ATCW_WAIT: begin
          if (!rd_reg && !rd_pend_reg) begin
            addr_reg <= ADDR_BUF_CTRL;
            rd_reg <= 1'b1;
          end else if (rd_pend_reg && BUS.rdata[BIT_ROOM]) begin
            word_reg <= '0;
            step_reg <= '0;
            st_reg <= ATCW_WRITE;
          end
        end
        ATCW_WRITE: begin
          wr_reg <= 1'b1;
          step_reg <= step_reg + 3'h1;
          case (step_reg)
            // start flag ahead of first word
            3'h0: begin
              addr_reg <= ADDR_BUF_CTRL;
              wdata_reg <= RST_CTRL_KEEP | {7'h00, word_reg == '0};
            end
            3'h1: begin
              addr_reg <= ADDR_BYTE3;
              wdata_reg <= cell_byte(seed_reg, word_reg, 2'd0);
            end
            3'h2: begin
              addr_reg <= ADDR_BYTE2;
              wdata_reg <= cell_byte(seed_reg, word_reg, 2'd1);
            end
            3'h3: begin
              addr_reg <= ADDR_BYTE1;
              wdata_reg <= cell_byte(seed_reg, word_reg, 2'd2);
            end
            // start flag cleared after first word
            3'h5: begin
              addr_reg <= ADDR_BUF_CTRL;
              wdata_reg <= RST_CTRL_KEEP;
              step_reg <= 3'h1;
            end
            default: begin
              addr_reg <= ADDR_BYTE0;
              wdata_reg <= cell_byte(seed_reg, word_reg, 2'd3);
              step_reg <= (word_reg == '0) ? 3'h5 : 3'h1;
              word_reg <= word_reg + 4'h1;
              if (word_reg == 4'(WORDS_PER_CELL - 1)) st_reg <= ATCW_DONE;
            end
          endcase
        end
        ATCW_DONE: begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
          step_reg <= '0;
          st_reg <= ATCW_IDLE;
        end
        default: st_reg <= ATCW_IDLE;
      endcase
    end
  end

  assign BUS.addr = addr_reg;
  assign BUS.wdata = wdata_reg;
  assign BUS.wr = wr_reg;
  assign BUS.rd = rd_reg;
  assign BUS.tx_ready = TX_READY_I;
  assign BUSY_O = busy_reg;
  assign DONE_O = done_reg;
endmodule

// >>> src/atcw_pkg.sv
// Constants for the cell insertion write path, shared by both ends
// How it works
// - Interrupt when buffered cell leaves, if enabled
// - Software sets enable bit 4 first
// - Interrupt output driven low on event
// - Status bit 4 set, cleared on read
// - Software writes cell after room confirmed
// - Start flag set marks next word first
// - Start flag cleared means continuation words
// - First byte goes to byte-3 register
// - Second byte goes to byte-2 register
// - Third byte goes to byte-1 register
// - Fourth byte written last, byte-0 register
// - Room flag shows space for a cell
// - Fourteen words per cell, fixed order
// - Reset bit low then high flushes buffer
// - Data register reads return extraction data
package atcw_pkg;
  localparam logic [15:0] ADDR_IRQ_FLAGS = 16'h0f0b;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'h0f0f;
  localparam logic [15:0] ADDR_BUF_CTRL = 16'h0f13;
  localparam logic [15:0] ADDR_BYTE3 = 16'h0f14;
  localparam logic [15:0] ADDR_BYTE2 = 16'h0f15;
  localparam logic [15:0] ADDR_BYTE1 = 16'h0f16;
  localparam logic [15:0] ADDR_BYTE0 = 16'h0f17;
  localparam int BIT_INS_IRQ = 4;
  localparam int BIT_SOC = 0;
  localparam int BIT_ROOM = 1;
  localparam int BIT_INS_RST_N = 2;
  localparam int BIT_EXT_CELL_PRESENT_FLAG = 3;
  localparam int BIT_EXT_RST_N = 4;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;
  localparam logic [7:0] RST_CTRL_KEEP = 8'h14;
  localparam int WORDS_PER_CELL = 14;
  localparam int BUF_CELLS = 2;
  localparam int BUF_WORDS = WORDS_PER_CELL * BUF_CELLS;
  localparam int PTR_W = 5;
  localparam logic [7:0] EXT_READ_DATA = 8'h00;
  typedef enum logic [2:0] {ATCW_IDLE, ATCW_WRITE, ATCW_WAIT, ATCW_DONE} atcw_op_t;
endpackage

// >>> src/atcw_if.sv
// Byte-wide processor bus and transmit path between the two ends
interface atcw_if (input wire logic MCLK_I);
  logic [15:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic wr;
  logic rd;
  logic irq_n;
  logic [31:0] tx_word;
  logic tx_soc;
  logic tx_valid;
  logic tx_ready;
  modport dev (input addr, wdata, wr, rd, tx_ready, output rdata, irq_n, tx_word, tx_soc,
    tx_valid);
  modport cpu (output addr, wdata, wr, rd, tx_ready, input rdata, irq_n, tx_word, tx_soc,
    tx_valid);
endinterface

// >>> src/atcw_dev.sv
// Device end: insertion buffer, its registers and the interrupt
module atcw_dev
  import atcw_pkg::*;
(
  input wire logic MCLK_I, // 40 MHz clock
  input wire logic RESET_I, // Sync reset, active high
  atcw_if.dev BUS, // Processor bus and transmit path
  input wire logic TX_IDLE_I, // Transmit FIFO has no user cells
  output logic CELL_SENT_O // Pulse: one cell fully sent
);
  import atcw_pkg::*;

  logic [31:0] mem_reg [BUF_WORDS];
  logic soc_mem_reg [BUF_WORDS];
  logic [PTR_W-1:0] wp_reg, rp_reg;
  logic [PTR_W:0] cnt_reg;
  logic [7:0] b3_reg, b2_reg, b1_reg;
  logic [7:0] mask_reg, flags_reg, rdata_reg;
  logic soc_reg, ins_rst_n_reg, ext_rst_n_reg, irq_n_reg, sent_reg;
  logic [3:0] left_reg;
  logic [31:0] txw_reg;
  logic txs_reg, txv_reg;
  logic wr_word, pop, cell_done, room, flush;

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    return (p == PTR_W'(BUF_WORDS - 1)) ? '0 : p + 1'b1;
  endfunction

  assign room = (cnt_reg <= (PTR_W+1)'(BUF_WORDS - WORDS_PER_CELL));
  assign wr_word = BUS.wr && BUS.addr == ADDR_BYTE0 && cnt_reg != (PTR_W+1)'(BUF_WORDS);
  assign pop = (!txv_reg || BUS.tx_ready) && cnt_reg != '0 && TX_IDLE_I;
  assign cell_done = txv_reg && BUS.tx_ready && left_reg == 4'h1;
  // rising edge of active-low reset bit
  assign flush = BUS.wr && BUS.addr == ADDR_BUF_CTRL && !ins_rst_n_reg && BUS.wdata[BIT_INS_RST_N];

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      b3_reg <= '0;
      b2_reg <= '0;
      b1_reg <= '0;
    end else if (BUS.wr) begin
      if (BUS.addr == ADDR_BYTE3) b3_reg <= BUS.wdata;
      if (BUS.addr == ADDR_BYTE2) b2_reg <= BUS.wdata;
      if (BUS.addr == ADDR_BYTE1) b1_reg <= BUS.wdata;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      mask_reg <= RST_IRQ_MASK;
      soc_reg <= 1'b0;
      ins_rst_n_reg <= RST_CTRL_KEEP[BIT_INS_RST_N];
      ext_rst_n_reg <= RST_CTRL_KEEP[BIT_EXT_RST_N];
    end else if (BUS.wr) begin
      if (BUS.addr == ADDR_IRQ_MASK) mask_reg <= BUS.wdata;
      if (BUS.addr == ADDR_BUF_CTRL) begin
        soc_reg <= BUS.wdata[BIT_SOC];
        ins_rst_n_reg <= BUS.wdata[BIT_INS_RST_N];
        ext_rst_n_reg <= BUS.wdata[BIT_EXT_RST_N];
      end
    end
  end

  for (genvar i = 0; i < BUF_WORDS; i++) begin : g_mem
    always_ff @(posedge MCLK_I) begin
      if (RESET_I) begin
        mem_reg[i] <= '0;
        soc_mem_reg[i] <= 1'b0;
      end else if (wr_word && wp_reg == PTR_W'(i)) begin
        mem_reg[i] <= {b3_reg, b2_reg, b1_reg, BUS.wdata};
        soc_mem_reg[i] <= soc_reg;
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I || flush) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (wr_word) wp_reg <= ptr_inc(wp_reg);
      if (pop) rp_reg <= ptr_inc(rp_reg);
      cnt_reg <= cnt_reg + (PTR_W+1)'(wr_word) - (PTR_W+1)'(pop);
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I || flush) begin
      txw_reg <= '0;
      txs_reg <= 1'b0;
      txv_reg <= 1'b0;
      left_reg <= '0;
    end else begin
      if (pop) begin
        txw_reg <= mem_reg[rp_reg];
        txs_reg <= soc_mem_reg[rp_reg];
        txv_reg <= 1'b1;
      end else if (BUS.tx_ready) begin
        txv_reg <= 1'b0;
      end
      if (txv_reg && BUS.tx_ready) begin
        if (txs_reg) left_reg <= 4'(WORDS_PER_CELL - 1);
        else if (left_reg != '0) left_reg <= left_reg - 4'h1;
      end
    end
  end

  logic sent_now;
  assign sent_now = cell_done && !txs_reg;

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      flags_reg <= '0;
      irq_n_reg <= 1'b1;
      sent_reg <= 1'b0;
    end else begin
      sent_reg <= sent_now;
      // set wins over clear on read
      if (sent_now) flags_reg[BIT_INS_IRQ] <= 1'b1;
      else if (BUS.rd && BUS.addr == ADDR_IRQ_FLAGS) flags_reg <= '0;
      irq_n_reg <= !((flags_reg[BIT_INS_IRQ] || sent_now) && mask_reg[BIT_INS_IRQ]
        && !(BUS.rd && BUS.addr == ADDR_IRQ_FLAGS && !sent_now));
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      rdata_reg <= '0;
    end else if (BUS.rd) begin
      case (BUS.addr)
        ADDR_IRQ_FLAGS: rdata_reg <= flags_reg;
        ADDR_IRQ_MASK: rdata_reg <= mask_reg;
        ADDR_BUF_CTRL: rdata_reg <= {3'b000, ext_rst_n_reg, 1'b0, ins_rst_n_reg, room, soc_reg};
        // data reads come from extraction side
        ADDR_BYTE3, ADDR_BYTE2, ADDR_BYTE1, ADDR_BYTE0: rdata_reg <= EXT_READ_DATA;
        default: rdata_reg <= '0;
      endcase
    end
  end

  assign BUS.rdata = rdata_reg;
  assign BUS.irq_n = irq_n_reg;
  assign BUS.tx_word = txw_reg;
  assign BUS.tx_soc = txs_reg;
  assign BUS.tx_valid = txv_reg;
  assign CELL_SENT_O = sent_reg;
endmodule

// >>> tb/atcw_chk.sv
// Concurrent checks on the bus and transmit path between both ends
module atcw_chk
  import atcw_pkg::*;
(
  input wire logic MCLK_I, // Clock
  input wire logic RESET_I, // Sync reset
  input wire logic [15:0] addr, // Bus address
  input wire logic [7:0] wdata, // Write byte
  input wire logic [7:0] rdata, // Read byte
  input wire logic wr, // Write pulse
  input wire logic rd, // Read pulse
  input wire logic irq_n, // Interrupt, low active
  input wire logic [31:0] tx_word, // Path word
  input wire logic tx_soc, // First word mark
  input wire logic tx_valid, // Word offered
  input wire logic tx_ready // Word taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_reg;
  logic mask_reg;
  logic ins_rst_n_reg;
  logic flush_wr;
  logic acc;
  logic ev;
  logic rd_flags;
  assign acc = tx_valid && tx_ready;
  assign ev = acc && cnt_reg == 4'd13 && mask_reg;
  assign rd_flags = rd && addr == ADDR_IRQ_FLAGS;
  assign flush_wr = wr && addr == ADDR_BUF_CTRL && !ins_rst_n_reg && wdata[BIT_INS_RST_N];
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      ins_rst_n_reg <= RST_CTRL_KEEP[BIT_INS_RST_N];
    end else if (wr && addr == ADDR_BUF_CTRL) begin
      ins_rst_n_reg <= wdata[BIT_INS_RST_N];
    end
  end
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      cnt_reg <= 4'd0;
    end else if (acc) begin
      cnt_reg <= (cnt_reg == 4'd13) ? 4'd0 : cnt_reg + 4'd1;
    end
  end
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      mask_reg <= RST_IRQ_MASK[BIT_INS_IRQ];
    end else if (wr && addr == ADDR_IRQ_MASK) begin
      mask_reg <= wdata[BIT_INS_IRQ];
    end
  end
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);
  irq_on_cell_a: assert property (ev |=> !irq_n)
    else $error("interrupt not low after last word");
  irq_cause_a: assert property ($fell(irq_n) |-> $past(ev))
    else $error("interrupt low without a sent cell");
  irq_hold_a: assert property ((!irq_n && !rd_flags && !$past(rd_flags)) |=> !irq_n)
    else $error("interrupt released without status read");
  irq_clear_a: assert property ((rd_flags && !ev) ##1 (!ev) [*2] |-> irq_n)
    else $error("interrupt kept after status read");
  flag_read_a: assert property ((rd_flags && !irq_n) |=> rdata[BIT_INS_IRQ])
    else $error("status bit not set while interrupt low");
  byte_read_a: assert property ((rd && addr >= ADDR_BYTE3 && addr <= ADDR_BYTE0)
    |=> rdata == EXT_READ_DATA)
    else $error("data register read not extraction data");
  word_hold_a: assert property ((tx_valid && !tx_ready)
    |=> tx_valid && $stable(tx_word) && $stable(tx_soc))
    else $error("offered word changed before taken");
  soc_first_a: assert property (acc |-> tx_soc == (cnt_reg == 4'd0))
    else $error("first word mark misplaced");
  flush_empty_a: assert property (flush_wr |=> !tx_valid)
    else $error("word offered after buffer flush");
  cover property (ev);
  cover property (tx_valid && !tx_ready);
  cover property (rd_flags && !irq_n);
endmodule

// >>> tb/tb_atm_tx_cell_insertion_write.sv
// Testbench joining both ends and checking the cells that leave
module tb_atm_tx_cell_insertion_write;
  import atcw_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic send = 1'b0;
  logic tx_idle = 1'b0;
  logic tx_rdy = 1'b1;
  logic stall = 1'b0;
  logic [7:0] fill = 8'h00;
  logic cell_sent;
  logic busy;
  logic done;
  logic got;
  int fails = 0;
  int num_checks = 0;
  int sent_cells = 0;
  int pulses = 0;
  int widx = 0;
  int irqs = 0;
  int flag_reads = 0;
  logic irq_q = 1'b1;
  logic rd_fl_q = 1'b0;
  logic rd_dat_q = 1'b0;
  logic [7:0] seeds[$];
  always #12.5 clk = ~clk;
  atcw_if bus (.MCLK_I(clk));
  atcw_dev i_atcw_dev (.MCLK_I(clk), .RESET_I(rst), .BUS(bus.dev), .TX_IDLE_I(tx_idle),
    .CELL_SENT_O(cell_sent));
  atcw_cpu i_atcw_cpu (.MCLK_I(clk), .RESET_I(rst), .BUS(bus.cpu), .SEND_I(send),
    .FILL_I(fill), .TX_READY_I(tx_rdy), .BUSY_O(busy), .DONE_O(done));
  atcw_chk i_atcw_chk (.MCLK_I(clk), .RESET_I(rst), .addr(bus.addr), .wdata(bus.wdata),
    .rdata(bus.rdata), .wr(bus.wr), .rd(bus.rd), .irq_n(bus.irq_n), .tx_word(bus.tx_word),
    .tx_soc(bus.tx_soc), .tx_valid(bus.tx_valid), .tx_ready(bus.tx_ready));
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("mismatch t=%0t %s", $time, msg);
    end
  endtask
  function automatic logic [31:0] exp_word(input logic [7:0] s, input int w);
    logic [7:0] b;
    b = s + 8'(4 * w);
    return {b, b + 8'd1, b + 8'd2, b + 8'd3};
  endfunction
  // Far side stalls every other cycle when asked
  always @(posedge clk) begin
    if (stall) tx_rdy <= ~tx_rdy;
  end
  always @(posedge clk) begin
    if (cell_sent === 1'b1) pulses++;
    if (!rst && rd_fl_q) begin
      flag_reads++;
      chk(bus.rdata[BIT_INS_IRQ] === 1'b1, "status bit on read");
    end
    if (!rst && rd_dat_q) chk(bus.rdata === EXT_READ_DATA, "data register read");
    if (!rst && irq_q === 1'b1 && bus.irq_n === 1'b0) irqs++;
    irq_q = bus.irq_n;
    rd_fl_q = (bus.rd === 1'b1 && bus.addr == ADDR_IRQ_FLAGS);
    rd_dat_q = (bus.rd === 1'b1 && bus.addr == ADDR_BYTE3);
    if (!rst && bus.tx_valid === 1'b1 && bus.tx_ready === 1'b1) begin
      chk(seeds.size() > 0 && bus.tx_word === exp_word(seeds[0], widx), "cell word");
      chk(bus.tx_soc === (widx == 0), "first word mark");
      widx = (widx + 1) % WORDS_PER_CELL;
      if (widx == 0) begin
        void'(seeds.pop_front());
        sent_cells++;
      end
    end
  end
  task automatic start(input logic [7:0] s);
    seeds.push_back(s);
    @(posedge clk);
    send <= 1'b1;
    fill <= s;
    @(posedge clk);
    send <= 1'b0;
  endtask
  task automatic wait_done(input int lim, output logic g);
    g = 1'b0;
    repeat (lim) if (!g) begin
      @(negedge clk);
      g = (done === 1'b1);
    end
  endtask
  task automatic wait_sent(input int n);
    repeat (3000) if (sent_cells < n) @(posedge clk);
    repeat (6) @(negedge clk);
  endtask
  task automatic t_one_cell;
    @(posedge clk);
    tx_idle <= 1'b1;
    start(8'h10);
    wait_done(200, got);
    chk(got, "one cell written");
    wait_sent(1);
    chk(sent_cells == 1 && pulses == 1, "one cell sent");
    chk(irqs == 1, "interrupt after cell");
    chk(flag_reads == 1 && bus.irq_n === 1'b1, "status read clears interrupt");
    $display("test one_cell finished");
  endtask
  task automatic t_stall;
    @(posedge clk);
    tx_idle <= 1'b0;
    start(8'h40);
    wait_done(200, got);
    chk(got, "first held cell");
    start(8'hf0);
    wait_done(200, got);
    chk(got, "second held cell");
    // Buffer full: a third cell must wait for room
    start(8'h7c);
    wait_done(150, got);
    chk(!got && busy === 1'b1, "third cell held off");
    @(posedge clk);
    stall <= 1'b1;
    tx_idle <= 1'b1;
    wait_done(600, got);
    chk(got, "third cell after room");
    wait_sent(4);
    @(posedge clk);
    stall <= 1'b0;
    @(posedge clk);
    tx_rdy <= 1'b1;
    chk(sent_cells == 4 && pulses == 4 && seeds.size() == 0, "cells sent in order");
    chk(flag_reads >= 2 && bus.irq_n === 1'b1, "interrupts acknowledged");
    $display("test stall finished");
  endtask
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    t_one_cell;
    t_stall;
    final_report;
  end
  // Tests need well under 8000 cycles
  initial begin
    #(25 * 8000);
    fails++;
    $display("mismatch t=%0t watchdog expired", $time);
    final_report;
  end
endmodule
